// >>> mas_consts.svh
/*
 * offsets, field positions, reset values and counts of the monitor converter sequencer.
 * assumes it is included by bare name from the package and the testbench.
 */
`ifndef MAS_CONSTS_SVH
`define MAS_CONSTS_SVH

// register offsets on the register port
`define MAS_OFF_RES_HI      8'h07
`define MAS_OFF_RES_LO      8'h08
`define MAS_OFF_CTRL        8'h09
`define MAS_OFF_CHAN        8'h0A
`define MAS_OFF_ILIM        8'h10

// control register fields
`define MAS_CTRL_EN_BIT     7
`define MAS_CTRL_ONESHOT    6
`define MAS_CTRL_POLL       5
`define MAS_CTRL_BUFDIS     4

// channel select and status register fields
`define MAS_CHAN_CONV_LSB   0
`define MAS_CHAN_READ_LSB   3
`define MAS_CHAN_READY_BIT  6

// reset values
`define MAS_RST_CTRL        8'h00
`define MAS_RST_CHAN        8'h00
`define MAS_RST_ILIM        8'h00

// converter figures
`define MAS_NUM_CH          7
`define MAS_RES_W           12
`define MAS_CONV_CYCLES     4096
`define MAS_CNT_W           13
`define MAS_LAST_CH         3'h6
`define MAS_ALL_SEEN        7'h7F

`endif

// >>> mas_front_model.sv
/*
 * front end model: converter bitstream whose density follows the selected input.
 * assumes the selector code holds still through each conversion.
 */
`timescale 1ns/10ps
`default_nettype none
module mas_front_model (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            reset_n,
	// selector and per-input densities
	input  wire logic [2:0]      mux_sel,
	input  wire logic [6:0][6:0] level,
	// bitstream
	output var  logic            bit_out
);
	logic [5:0] phase;

	// free running phase, period of 64 cycles
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			phase <= 6'h0;
		else
			phase <= phase + 6'h1;
	end

	// ones per 64 cycles equal the level of the selected input
	always_comb bit_out = (mux_sel < 3'h7) && ({1'b0, phase} < level[mux_sel]);
endmodule // mas_front_model
`default_nettype wire

// >>> mas_pkg.sv
/*
 * types of the monitor converter sequencer.
 * assumes mas_consts.svh is on the include path.
 */
`default_nettype none
package mas_pkg;
`include "mas_consts.svh"

	// sequencer phase
	typedef enum logic [0:0] {
		MAS_IDLE,
		MAS_CONVERT
	} mas_phase_t;

	// complete state of the sequencer top
	typedef struct packed {
		mas_phase_t                 phase;
		logic                       en;
		logic                       one_shot;
		logic                       poll_all_select;
		logic                       buffer_disable;
		logic [2:0]                 convert_channel_sel;
		logic [2:0]                 readback_channel_sel;
		logic                       ready;
		logic                       irq_n;
		logic                       run_poll;
		logic [`MAS_NUM_CH-1:0]     seen;
		logic [2:0]                 cur_ch;
		logic [`MAS_CNT_W-1:0]      cnt;
		logic [`MAS_CNT_W-1:0]      ones;
		logic [7:0]                 ilim;
		logic [7:0]                 rdata;
		logic                       rvalid;
		logic                       wr_en;
		logic [2:0]                 wr_addr;
		logic [`MAS_RES_W-1:0]      wr_data;
	} mas_state_t;
endpackage
`default_nettype wire

// >>> mas_res_if.sv
/*
 * carrier between the sequencer and its result store.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface mas_res_if #(
	parameter int RES_W = 12
);
	logic             wr_en;
	logic [2:0]       wr_addr;
	logic [RES_W-1:0] wr_data;
	logic [2:0]       rd_addr;
	logic [RES_W-1:0] rd_data;

	// sequencer side
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	// store side
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> mas_result_mem.sv
/*
 * per-channel result store, one word per channel, registered read data.
 * assumes addresses below NUM_CH; writes and reads on one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module mas_result_mem #(
	parameter int NUM_CH = 7,
	parameter int RES_W  = 12
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// store port
	mas_res_if.mem    res
);
	typedef struct packed {
		logic [NUM_CH-1:0][RES_W-1:0] word;
		logic [RES_W-1:0]             rd_data;
	} mas_mem_t;

	mas_mem_t s;
	mas_mem_t next_s;

	// write one word, pick the readback word
	always_comb begin
		next_s = s;
		if (res.wr_en && (32'(res.wr_addr) < NUM_CH)) begin
			next_s.word[res.wr_addr] = res.wr_data;
		end
		if (32'(res.rd_addr) < NUM_CH) begin
			next_s.rd_data = s.word[res.rd_addr];
		end else begin
			next_s.rd_data = '0;
		end
	end

	// state register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign res.rd_data = s.rd_data;
endmodule // mas_result_mem
`default_nettype wire

// >>> mas_sequencer.sv
/*
 * monitor converter sequencer: register map, single-shot and polling control,
 * decimation of the converter bitstream and the active-low host interrupt.
 * assumes a register port driven by the serial host engine on the same clock,
 * and a modulator bitstream on the same clock as the design.
 */
// Function
// - one shared converter yields every result at twelve bits.
// - input selector picks one of seven inputs by a three-bit field.
// - one result word per channel, one shown through a readback selector.
// - a single enable bit in the control register at 0x09 runs the converter.
// - in single-shot mode, writing enable starts one conversion of only the selected channel.
// - single-shot completion sets ready, pulls interrupt low, clears enable.
// - result bits 11:4 sit in 0x07, bits 3:0 in 0x08.
// - interrupt low and ready held until the result is read; read releases.
// - polling steps through all channels, overwriting each result continuously.
// - polling sets ready only after every channel was converted once.
// - polling never asserts the interrupt; ready is the only indication.
// - channel codes: output current, output voltage, input voltage, ... pin.
`timescale 1ns/10ps
`default_nettype none
module mas_sequencer
	import mas_pkg::*;
#(
	parameter int CONV_CYCLES = `MAS_CONV_CYCLES
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// register port from the serial host engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	output var  logic       reg_rvalid,
	// converter front end
	input  wire logic       modulator_bit,
	output var  logic [2:0] convert_mux_sel,
	// host interrupt and limit setting
	output var  logic       host_interrupt_n,
	output var  logic [7:0] input_current_limit_setting
);
	mas_state_t s;
	mas_state_t next_s;
	mas_res_if #(.RES_W(`MAS_RES_W)) res ();

	// saturate the ones count to the twelve-bit result
	function automatic logic [`MAS_RES_W-1:0] sat_result(input logic [`MAS_CNT_W-1:0] ones);
		sat_result = ones[`MAS_CNT_W-1] ? {`MAS_RES_W{1'b1}} : ones[`MAS_RES_W-1:0];
	endfunction

	// next polled channel, wrapping after the last
	function automatic logic [2:0] step_ch(input logic [2:0] ch);
		step_ch = (ch == `MAS_LAST_CH) ? 3'h0 : ch + 3'h1;
	endfunction

	// only the two documented mode settings are valid
	function automatic logic mode_ok(input logic one_shot, input logic poll, input logic bufdis);
		mode_ok = !bufdis && (one_shot != poll);
	endfunction

	wire logic wr_ctrl    = reg_wr && (reg_addr == `MAS_OFF_CTRL);
	wire logic wr_chan    = reg_wr && (reg_addr == `MAS_OFF_CHAN);
	wire logic rd_result  = reg_rd && ((reg_addr == `MAS_OFF_RES_HI) || (reg_addr == `MAS_OFF_RES_LO));
	wire logic conv_done  = (s.phase == MAS_CONVERT) && (s.cnt == `MAS_CNT_W'(CONV_CYCLES - 1));
	wire logic start_ok   = wr_ctrl && reg_wdata[`MAS_CTRL_EN_BIT]
		&& mode_ok(reg_wdata[`MAS_CTRL_ONESHOT], reg_wdata[`MAS_CTRL_POLL], reg_wdata[`MAS_CTRL_BUFDIS]);

	// sequencer, register map and decimator
	always_comb begin
		next_s        = s;
		next_s.wr_en  = 1'b0;
		next_s.rvalid = 1'b0;

		// reading the result releases a single-shot completion
		if (rd_result && !s.run_poll) begin
			next_s.ready = 1'b0;
			next_s.irq_n = 1'b1;
		end

		// register writes
		if (wr_chan) begin
			next_s.convert_channel_sel  = reg_wdata[`MAS_CHAN_CONV_LSB +: 3];
			next_s.readback_channel_sel = reg_wdata[`MAS_CHAN_READ_LSB +: 3];
		end
		if (reg_wr && (reg_addr == `MAS_OFF_ILIM)) begin
			next_s.ilim = reg_wdata;
		end
		if (wr_ctrl) begin
			next_s.en              = reg_wdata[`MAS_CTRL_EN_BIT];
			next_s.one_shot        = reg_wdata[`MAS_CTRL_ONESHOT];
			next_s.poll_all_select = reg_wdata[`MAS_CTRL_POLL];
			next_s.buffer_disable  = reg_wdata[`MAS_CTRL_BUFDIS];
			if (start_ok) begin
				// a new run restarts the decimator and the flags
				next_s.phase    = MAS_CONVERT;
				next_s.run_poll = reg_wdata[`MAS_CTRL_POLL];
				next_s.cur_ch   = reg_wdata[`MAS_CTRL_POLL] ? 3'h0 : s.convert_channel_sel;
				next_s.cnt      = '0;
				next_s.ones     = '0;
				next_s.seen     = '0;
				next_s.ready    = 1'b0;
				next_s.irq_n    = 1'b1;
			end else if (!reg_wdata[`MAS_CTRL_EN_BIT]) begin
				next_s.phase = MAS_IDLE; // disable aborts a run
			end
		end else begin
			case (s.phase)
				MAS_IDLE: begin
					next_s.cnt = '0;
				end
				MAS_CONVERT: begin
					// count modulator ones across the conversion window
					next_s.cnt  = s.cnt + `MAS_CNT_W'(1);
					next_s.ones = s.ones + `MAS_CNT_W'(modulator_bit);
					if (conv_done) begin
						next_s.wr_en   = 1'b1;
						next_s.wr_addr = s.cur_ch;
						next_s.wr_data = sat_result(next_s.ones);
						next_s.cnt     = '0;
						next_s.ones    = '0;
						if (s.run_poll) begin
							next_s.seen   = s.seen | (7'h01 << s.cur_ch);
							next_s.cur_ch = step_ch(s.cur_ch);
							if (next_s.seen == `MAS_ALL_SEEN) begin
								next_s.ready = 1'b1;
							end
						end else begin
							next_s.ready = 1'b1;
							next_s.irq_n = 1'b0;
							next_s.en    = 1'b0;
							next_s.phase = MAS_IDLE;
						end
					end
				end
				default: begin
					next_s.phase = MAS_IDLE;
				end
			endcase
		end

		// register reads, answered one cycle later
		if (reg_rd) begin
			next_s.rvalid = 1'b1;
			case (reg_addr)
				`MAS_OFF_RES_HI: next_s.rdata = res.rd_data[11:4];
				`MAS_OFF_RES_LO: next_s.rdata = {res.rd_data[3:0], 4'h0};
				`MAS_OFF_CTRL: next_s.rdata = {s.en, s.one_shot, s.poll_all_select, s.buffer_disable, 4'h0};
				`MAS_OFF_CHAN: next_s.rdata = {1'b0, s.ready, s.readback_channel_sel, s.convert_channel_sel};
				`MAS_OFF_ILIM: next_s.rdata = s.ilim;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s                      <= '0;
			s.phase                <= MAS_IDLE;
			s.irq_n                <= 1'b1;
			s.ilim                 <= `MAS_RST_ILIM;
			s.convert_channel_sel  <= 3'(`MAS_RST_CHAN >> `MAS_CHAN_CONV_LSB);
			s.readback_channel_sel <= 3'(`MAS_RST_CHAN >> `MAS_CHAN_READ_LSB);
		end else begin
			s <= next_s;
		end
	end

	// result store and readback selector
	mas_result_mem #(
		.NUM_CH (`MAS_NUM_CH),
		.RES_W  (`MAS_RES_W)
	) u_mem (
		.clock   (clock),
		.reset_n (reset_n),
		.res     (res.mem)
	);

	// carrier and outputs, all from flops
	assign res.wr_en                   = s.wr_en;
	assign res.wr_addr                 = s.wr_addr;
	assign res.wr_data                 = s.wr_data;
	assign res.rd_addr                 = s.readback_channel_sel;
	assign reg_rdata                   = s.rdata;
	assign reg_rvalid                  = s.rvalid;
	assign convert_mux_sel             = s.cur_ch;
	assign host_interrupt_n            = s.irq_n;
	assign input_current_limit_setting = s.ilim;

	// named sequences for the checks
	sequence s_done_single;
		conv_done && !s.run_poll && !wr_ctrl;
	endsequence

	sequence s_done_poll;
		conv_done && s.run_poll && !wr_ctrl;
	endsequence

	property p_single_done;
		@(posedge clock) disable iff (!reset_n)
		s_done_single |=> (s.ready && !host_interrupt_n && !s.en && s.phase == MAS_IDLE);
	endproperty
	a_single_done: assert property (p_single_done) else $error("single-shot completion flags wrong");

	property p_irq_held;
		@(posedge clock) disable iff (!reset_n)
		(!host_interrupt_n && !rd_result && !start_ok) |=> (!host_interrupt_n && s.ready);
	endproperty
	a_irq_held: assert property (p_irq_held) else $error("interrupt released without a result read");

	property p_read_release;
		@(posedge clock) disable iff (!reset_n)
		(rd_result && !s.run_poll && !conv_done) |=> (host_interrupt_n && !s.ready);
	endproperty
	a_read_release: assert property (p_read_release) else $error("result read did not release interrupt");

	property p_poll_no_irq;
		@(posedge clock) disable iff (!reset_n)
		(s.phase == MAS_CONVERT && s.run_poll) |=> !$fell(host_interrupt_n);
	endproperty
	a_poll_no_irq: assert property (p_poll_no_irq) else $error("interrupt asserted while polling");

	property p_poll_ready_all;
		@(posedge clock) disable iff (!reset_n)
		($rose(s.ready) && s.run_poll) |-> (s.seen == `MAS_ALL_SEEN);
	endproperty
	a_poll_ready_all: assert property (p_poll_ready_all) else $error("poll ready before all channels");

	property p_poll_step;
		@(posedge clock) disable iff (!reset_n)
		s_done_poll |=> (convert_mux_sel == step_ch($past(convert_mux_sel)) && res.wr_en);
	endproperty
	a_poll_step: assert property (p_poll_step) else $error("poll did not step and store");

	property p_bad_mode_idle;
		@(posedge clock) disable iff (!reset_n)
		(wr_ctrl && !start_ok && s.phase == MAS_IDLE) |=> (s.phase == MAS_IDLE && $stable(s.ready) ##1 s.phase == MAS_IDLE);
	endproperty
	a_bad_mode_idle: assert property (p_bad_mode_idle) else $error("invalid mode started a conversion");

	property p_start_single;
		@(posedge clock) disable iff (!reset_n)
		(start_ok && !reg_wdata[`MAS_CTRL_POLL]) |=> (s.phase == MAS_CONVERT && convert_mux_sel == $past(s.convert_channel_sel));
	endproperty
	a_start_single: assert property (p_start_single) else $error("single-shot start on wrong channel");

	property p_single_hold_ch;
		@(posedge clock) disable iff (!reset_n)
		(s.phase == MAS_CONVERT && !s.run_poll) ##1 (s.phase == MAS_CONVERT) |-> $stable(convert_mux_sel);
	endproperty
	a_single_hold_ch: assert property (p_single_hold_ch) else $error("single-shot channel moved");

	property p_read_hi;
		@(posedge clock) disable iff (!reset_n)
		(reg_rd && reg_addr == `MAS_OFF_RES_HI) |=> (reg_rvalid && reg_rdata == $past(res.rd_data[11:4]));
	endproperty
	a_read_hi: assert property (p_read_hi) else $error("upper result byte wrong");

	property p_read_lo;
		@(posedge clock) disable iff (!reset_n)
		(reg_rd && reg_addr == `MAS_OFF_RES_LO) |=> (reg_rvalid && reg_rdata == {$past(res.rd_data[3:0]), 4'h0});
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("lower result byte wrong");

	// every read strobe gets its valid pulse on the next edge
	property p_read_answer;
		@(posedge clock) disable iff (!reset_n)
		reg_rd |=> reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read strobe not answered");

	property p_disable_stops;
		@(posedge clock) disable iff (!reset_n)
		(wr_ctrl && !reg_wdata[`MAS_CTRL_EN_BIT]) |=> (s.phase == MAS_IDLE && !s.en);
	endproperty
	a_disable_stops: assert property (p_disable_stops) else $error("clearing enable did not stop the converter");

	property p_start_clears;
		@(posedge clock) disable iff (!reset_n)
		start_ok |=> (s.phase == MAS_CONVERT && !s.ready && host_interrupt_n);
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start did not begin a clean conversion");

	property p_store_write;
		@(posedge clock) disable iff (!reset_n)
		(conv_done && !wr_ctrl) |=> (res.wr_en && res.wr_addr == $past(s.cur_ch));
	endproperty
	a_store_write: assert property (p_store_write) else $error("result not stored to its channel word");

	property p_poll_ready_hold;
		@(posedge clock) disable iff (!reset_n)
		(s.ready && s.run_poll && s.phase == MAS_CONVERT && !wr_ctrl) |=> s.ready;
	endproperty
	a_poll_ready_hold: assert property (p_poll_ready_hold) else $error("poll ready dropped while polling");

	property p_poll_stays;
		@(posedge clock) disable iff (!reset_n)
		(s.phase == MAS_CONVERT && s.run_poll && !wr_ctrl) |=> (s.phase == MAS_CONVERT);
	endproperty
	a_poll_stays: assert property (p_poll_stays) else $error("polling stopped on its own");
endmodule // mas_sequencer
`default_nettype wire

// >>> monitor_adc_sequencer_tb.sv
/*
 * self-checking bench of the monitor converter sequencer.
 * assumes mas_consts.svh on the include path and a 64-cycle conversion.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mas_consts.svh"
module monitor_adc_sequencer_tb;
	logic            clock = 1'b0;
	logic            reset_n = 1'b0;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic [7:0]      reg_addr = 8'h00;
	logic [7:0]      reg_wdata = 8'h00;
	logic [7:0]      reg_rdata;
	logic [7:0]      limit;
	logic [7:0]      d;
	logic            reg_rvalid;
	logic            modulator_bit;
	logic            irq_n;
	logic            polling = 1'b0;
	logic [2:0]      mux;
	logic [2:0]      last_mux = 3'h6;
	logic [6:0][6:0] level = '0;
	logic [7:0]      bad_modes [3] = '{8'he0, 8'h80, 8'hd0};
	int              failures = 0;
	int              comparisons = 0;
	int              cycles = 0;

	// 10 MHz clock
	always #50 clock = ~clock;

	mas_sequencer #(.CONV_CYCLES(64)) dut_u (
		.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.modulator_bit(modulator_bit), .convert_mux_sel(mux), .host_interrupt_n(irq_n),
		.input_current_limit_setting(limit)
	);

	mas_front_model front_u (
		.clock(clock), .reset_n(reset_n), .mux_sel(mux), .level(level), .bit_out(modulator_bit)
	);

	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one comparison
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// register write, one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// register read, answer one cycle after the strobe
	task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, reg_rvalid});
		chk(name, exp, reg_rdata);
	endtask

	// expected result bytes for a level of ones
	function automatic logic [7:0] res_hi(input logic [6:0] v);
		return {5'h00, v[6:4]};
	endfunction
	function automatic logic [7:0] res_lo(input logic [6:0] v);
		return {v[3:0], 4'h0};
	endfunction

	// interrupt check, bounded wait for the low level
	task automatic wait_irq();
		for (int i = 0; i < 100 && irq_n !== 1'b0; i++)
			@(posedge clock);
		#1;
		chk("irq_low", 8'h00, {7'h00, irq_n});
	endtask

	// sweep order, quiet interrupt while polling, timeout
	always @(posedge clock) begin
		cycles++;
		if (polling && mux !== last_mux) begin
			chk("sweep", {5'h00, (last_mux == 3'h6) ? 3'h0 : last_mux + 3'h1}, {5'h00, mux});
			last_mux <= mux;
		end
		if (polling)
			chk("poll_irq", 8'h01, {7'h00, irq_n});
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'hca16_7173));
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		chk("irq_reset", 8'h01, {7'h00, irq_n});
		rdc("ctrl", `MAS_OFF_CTRL, 8'h00);
		rdc("chan", `MAS_OFF_CHAN, 8'h00);
		rdc("ilim", `MAS_OFF_ILIM, 8'h00);
		wr(8'h20, 8'hff);
		rdc("unmapped", 8'h20, 8'h00);
		d = 8'($urandom);
		wr(`MAS_OFF_ILIM, d);
		rdc("ilim", `MAS_OFF_ILIM, d);
		chk("limit", d, limit);
		$display("test registers done");
		for (logic [3:0] ch = 0; ch < 7; ch++) begin
			if (ch == 0)
				level[ch] <= 7'h40; // full scale corner
			else if (ch == 6)
				level[ch] <= 7'h00; // empty corner
			else
				level[ch] <= 7'($urandom % 65);
			wr(`MAS_OFF_CHAN, {2'b00, ch[2:0], ch[2:0]});
			wr(`MAS_OFF_CTRL, 8'hc0);
			repeat (2) @(posedge clock);
			#1 chk("mux", {5'h00, ch[2:0]}, {5'h00, mux});
			wait_irq();
			rdc("ready", `MAS_OFF_CHAN, {2'b01, ch[2:0], ch[2:0]});
			rdc("ctrl", `MAS_OFF_CTRL, 8'h40);
			chk("irq_held", 8'h00, {7'h00, irq_n});
			rdc("res_hi", `MAS_OFF_RES_HI, res_hi(level[ch]));
			@(posedge clock);
			#1 chk("irq_free", 8'h01, {7'h00, irq_n});
			rdc("res_lo", `MAS_OFF_RES_LO, res_lo(level[ch]));
			rdc("ready", `MAS_OFF_CHAN, {2'b00, ch[2:0], ch[2:0]});
		end
		$display("test single shot done");
		for (int i = 0; i < 3; i++) begin
			wr(`MAS_OFF_CTRL, bad_modes[i]);
			repeat (80) @(posedge clock);
			#1 chk("idle_irq", 8'h01, {7'h00, irq_n});
			rdc("ctrl", `MAS_OFF_CTRL, bad_modes[i]);
			rdc("ready", `MAS_OFF_CHAN, 8'h36);
		end
		$display("test idle modes done");
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 7; c++)
				level[c] <= 7'($urandom % 65);
			if (p == 0) begin
				wr(`MAS_OFF_CTRL, 8'ha0);
				polling <= 1'b1;
				repeat (100) @(posedge clock);
				rdc("early", `MAS_OFF_CHAN, 8'h36);
			end
			repeat (1000) @(posedge clock);
			rdc("ready", `MAS_OFF_CHAN, 8'h76);
			for (logic [3:0] ch = 0; ch < 7; ch++) begin
				wr(`MAS_OFF_CHAN, {2'b00, ch[2:0], 3'h6});
				repeat (2) @(posedge clock);
				rdc("poll_hi", `MAS_OFF_RES_HI, res_hi(level[ch]));
				rdc("poll_lo", `MAS_OFF_RES_LO, res_lo(level[ch]));
			end
		end
		polling <= 1'b0;
		wr(`MAS_OFF_CTRL, 8'h20);
		$display("test polling done");
		results();
	end
endmodule // monitor_adc_sequencer_tb
`default_nettype wire
